// [core/cfg_map_defs.svh]
`ifndef CFG_MAP_DEFS_SVH
`define CFG_MAP_DEFS_SVH

`define CFG_ADDR_W        17
`define CFG_DATA_W        32
`define CFG_SPACE_WORDS   17'h1097B
`define REGS_BASE         17'h00000
`define REGS_WORDS        4
`define REG_RESET         32'h00000000
`define TAB_B_BASE        17'h00010
`define TAB_B_WIDTH       33
`define TAB_B_DEPTH       16
`define TAB_C_BASE        17'h00040
`define TAB_C_WIDTH       181
`define TAB_C_DEPTH       8
`define MAC_LSB           0
`define MAC_BYTES         6
`define IPV6_LSB          48
`define IPV6_BYTES        16

`endif

// [core/cfg_map_pkg.sv]
package cfg_map_pkg;

    typedef struct packed {
        logic        write;
        logic [16:0] addr;
        logic [31:0] wdata;
    } cfgReq_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } cfgRsp_t;

    typedef enum logic [2:0] {
        BANK_NONE,
        BANK_REGS,
        BANK_TAB_B,
        BANK_TAB_C,
        BANK_OUTSIDE
    } bank_t;

    typedef logic [5:0][7:0]  macBytes_t;
    typedef logic [15:0][7:0] ipv6Bytes_t;

    typedef struct packed {
        macBytes_t  mac;
        ipv6Bytes_t ipv6;
    } netFields_t;

endpackage

// [core/net_byte_order.sv]
`timescale 1ns/10ps
`include "cfg_map_defs.svh"

module net_byte_order (
    input  wire logic [47:0]             macField,
    input  wire logic [127:0]            ipv6Field,
    output cfg_map_pkg::netFields_t      netOut
);

    genvar n;
    generate
        for (n = 0; n < `MAC_BYTES; n = n + 1) begin : g_mac
            // network byte 0 is the most significant field byte
            assign netOut.mac[n] = macField[8*(`MAC_BYTES-1-n) +: 8]; // RULE_06
        end
        for (n = 0; n < `IPV6_BYTES; n = n + 1) begin : g_ipv6
            // low network bytes in low field bytes, pairs swapped
            assign netOut.ipv6[n] = ipv6Field[8*(n ^ 1) +: 8]; // RULE_07
        end
    endgenerate

endmodule // net_byte_order

// [core/cfg_address_map.sv]
// Operation
// (RULE_01) every table is linear: entry N sits at base plus N times stride
// (RULE_02) entry stride is its width in bus words rounded up to a power of two
// (RULE_03) the whole configuration space spans exactly 67963 word addresses
// (RULE_04) integer fields are little endian: low field bits on low bus bits
// (RULE_05) a multi-word field keeps its low bits at the lowest address
// (RULE_06) MAC fields hold network byte 0 in the most significant byte
// (RULE_07) IPv6 fields keep low network bytes low, each byte pair swapped
// (RULE_08) each bank holds either a group of registers or exactly one table
// (RULE_09) master finishes one wide-bank entry before starting another there
// (RULE_10) wide banks gather words and commit the entry on its last word
`timescale 1ns/10ps
`include "cfg_map_defs.svh"

module cfg_address_map (
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    input  wire logic                           cfgValid,
    input  wire cfg_map_pkg::cfgReq_t           cfgReq,
    output logic                                cfgAck,
    output cfg_map_pkg::cfgRsp_t                cfgRsp,
    output logic [`REGS_WORDS-1:0][31:0]        regsOut,
    input  wire logic                           lookupValid,
    input  wire logic [2:0]                     lookupIdx,
    output logic                                fieldValid,
    output cfg_map_pkg::netFields_t             fieldOut
);

    localparam int B_WORDS  = (`TAB_B_WIDTH + 31) / 32;
    localparam int C_WORDS  = (`TAB_C_WIDTH + 31) / 32;
    localparam int B_SLOG2  = $clog2(B_WORDS);
    localparam int C_SLOG2  = $clog2(C_WORDS);
    localparam int B_HOLD_W = 32 << B_SLOG2;
    localparam int C_HOLD_W = 32 << C_SLOG2;
    localparam int B_SPAN   = `TAB_B_DEPTH << B_SLOG2;
    localparam int C_SPAN   = `TAB_C_DEPTH << C_SLOG2;
    localparam int B_EBITS  = $clog2(`TAB_B_DEPTH);
    localparam int C_EBITS  = $clog2(`TAB_C_DEPTH);

    logic rstnMeta;
    logic rstnSync;

    // reset release is synchronised; every reset flop below uses the late copy
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    cfg_map_pkg::bank_t          bank;
    logic [16:0]                 offB;
    logic [16:0]                 offC;
    logic [B_EBITS-1:0]          entB;
    logic [C_EBITS-1:0]          entC;
    logic [B_SLOG2-1:0]          wrdB;
    logic [C_SLOG2-1:0]          wrdC;

    always_comb begin
        offB = cfgReq.addr - `TAB_B_BASE;
        offC = cfgReq.addr - `TAB_C_BASE;
        entB = offB[B_SLOG2 +: B_EBITS]; // RULE_01 RULE_02
        entC = offC[C_SLOG2 +: C_EBITS]; // RULE_01 RULE_02
        wrdB = offB[B_SLOG2-1:0];
        wrdC = offC[C_SLOG2-1:0];
        // banks never overlap, so at most one of them owns an address
        if (cfgReq.addr >= `CFG_SPACE_WORDS) begin
            bank = cfg_map_pkg::BANK_OUTSIDE; // RULE_03
        end else if (cfgReq.addr < `REGS_BASE + 17'(`REGS_WORDS)) begin
            bank = cfg_map_pkg::BANK_REGS; // RULE_08
        end else if (cfgReq.addr >= `TAB_B_BASE && offB < 17'(B_SPAN)) begin
            bank = cfg_map_pkg::BANK_TAB_B; // RULE_08
        end else if (cfgReq.addr >= `TAB_C_BASE && offC < 17'(C_SPAN)) begin
            bank = cfg_map_pkg::BANK_TAB_C; // RULE_08
        end else begin
            bank = cfg_map_pkg::BANK_NONE;
        end
    end

    logic [`TAB_B_WIDTH-1:0]          tabB [`TAB_B_DEPTH];
    logic [`TAB_C_WIDTH-1:0]          tabC [`TAB_C_DEPTH];
    logic [`REGS_WORDS-1:0][31:0]     regs;
    logic [`REGS_WORDS-1:0][31:0]     next_regs;
    logic [B_HOLD_W-1:0]              holdB;
    logic [B_HOLD_W-1:0]              next_holdB;
    logic [C_HOLD_W-1:0]              holdC;
    logic [C_HOLD_W-1:0]              next_holdC;
    logic                             commitB;
    logic                             commitC;
    logic                             next_cfgAck;
    cfg_map_pkg::cfgRsp_t             next_cfgRsp;
    logic [B_HOLD_W-1:0]              padB;
    logic [C_HOLD_W-1:0]              padC;
    logic                             wr;

    always_comb begin
        wr          = cfgValid && cfgReq.write;
        next_regs   = regs;
        next_holdB  = holdB;
        next_holdC  = holdC;
        commitB     = 1'b0;
        commitC     = 1'b0;
        next_cfgAck = cfgValid;
        next_cfgRsp = '0;
        padB        = B_HOLD_W'(tabB[entB]);
        padC        = C_HOLD_W'(tabC[entC]);
        case (bank)
            cfg_map_pkg::BANK_REGS: begin
                if (wr) begin
                    next_regs[cfgReq.addr[1:0]] = cfgReq.wdata; // RULE_04
                end
                next_cfgRsp.rdata = regs[cfgReq.addr[1:0]];
            end
            cfg_map_pkg::BANK_TAB_B: begin
                if (wr) begin
                    next_holdB[32*wrdB +: 32] = cfgReq.wdata; // RULE_05
                    commitB = (wrdB == B_SLOG2'(B_WORDS - 1)); // RULE_10
                end
                // low word at the lowest address; padding words read zero
                next_cfgRsp.rdata = padB[32*wrdB +: 32]; // RULE_04 RULE_05
            end
            cfg_map_pkg::BANK_TAB_C: begin
                if (wr) begin
                    next_holdC[32*wrdC +: 32] = cfgReq.wdata; // RULE_05
                    commitC = (wrdC == C_SLOG2'(C_WORDS - 1)); // RULE_10
                end
                next_cfgRsp.rdata = padC[32*wrdC +: 32]; // RULE_04 RULE_05
            end
            cfg_map_pkg::BANK_OUTSIDE: begin
                next_cfgRsp.err = cfgValid; // RULE_03
            end
            default: begin
                next_cfgRsp.rdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            regs   <= {`REGS_WORDS{`REG_RESET}};
            holdB  <= '0;
            holdC  <= '0;
            cfgAck <= 1'b0;
            cfgRsp <= '0;
        end else begin
            regs   <= next_regs;
            holdB  <= next_holdB;
            holdC  <= next_holdC;
            cfgAck <= next_cfgAck;
            cfgRsp <= next_cfgRsp;
        end
    end

    // tables are plain storage; a lookup never sees a half-written entry
    always_ff @(posedge sys_clk) begin
        if (commitB) begin
            tabB[entB] <= next_holdB[`TAB_B_WIDTH-1:0]; // RULE_10
        end
        if (commitC) begin
            tabC[entC] <= next_holdC[`TAB_C_WIDTH-1:0]; // RULE_10
        end
    end

    assign regsOut = regs;

    cfg_map_pkg::netFields_t netNow;
    logic [`TAB_C_WIDTH-1:0] lookEntry;
    logic                    next_fieldValid;
    cfg_map_pkg::netFields_t next_fieldOut;

    assign lookEntry = tabC[lookupIdx];

    net_byte_order u_order (
        .macField  (lookEntry[`MAC_LSB +: 48]),
        .ipv6Field (lookEntry[`IPV6_LSB +: 128]),
        .netOut    (netNow)
    );

    always_comb begin
        next_fieldValid = lookupValid;
        next_fieldOut   = lookupValid ? netNow : fieldOut;
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            fieldValid <= 1'b0;
            fieldOut   <= '0;
        end else begin
            fieldValid <= next_fieldValid;
            fieldOut   <= next_fieldOut;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstnSync);

    logic [16:0] lastBAddr;
    assign lastBAddr = `TAB_B_BASE + 17'(B_WORDS - 1);

    sequence s_wr_lo;
        cfgValid && cfgReq.write && cfgReq.addr == `TAB_B_BASE;
    endsequence

    sequence s_wr_hi;
        cfgValid && cfgReq.write && cfgReq.addr == lastBAddr;
    endsequence

    a_entry_stride: assert property ( // RULE_01
        cfgValid && cfgReq.write && bank == cfg_map_pkg::BANK_TAB_B && wrdB == 1'b1
        |=> tabB[$past(entB)][32] == $past(cfgReq.wdata[0]))
        else $error("table entry not at base plus index times stride");
    // every table C address: entry is offset over eight, word is offset modulo eight
    a_stride_size: assert property ( // RULE_02
        cfgValid && bank == cfg_map_pkg::BANK_TAB_C
        |-> 17'(entC) == (cfgReq.addr - `TAB_C_BASE) / 17'h8
            && 17'(wrdC) == (cfgReq.addr - `TAB_C_BASE) % 17'h8)
        else $error("wide entry stride is not eight words");
    a_space_limit: assert property ( // RULE_03
        cfgValid && cfgReq.addr >= 17'h1097B
        |=> cfgAck && cfgRsp.err)
        else $error("address beyond the space not refused");
    // the host leaves one idle cycle between accesses
    a_reg_readback: assert property ( // RULE_04
        cfgValid && cfgReq.write && bank == cfg_map_pkg::BANK_REGS
        ##2 cfgValid && !cfgReq.write && cfgReq.addr == $past(cfgReq.addr, 2)
        |=> cfgRsp.rdata == $past(cfgReq.wdata, 3))
        else $error("register read back differs");
    a_low_word_first: assert property ( // RULE_05
        s_wr_lo ##2 s_wr_hi
        |=> tabB[0][31:0] == $past(cfgReq.wdata, 3))
        else $error("low field bits not at lowest address");
    a_mac_order: assert property ( // RULE_06
        lookupValid
        |=> fieldOut.mac[0] == $past(lookEntry[47:40]))
        else $error("MAC byte 0 not most significant");
    a_ipv6_swap: assert property ( // RULE_07
        lookupValid
        |=> fieldOut.ipv6[0] == $past(lookEntry[63:56])
            && fieldOut.ipv6[1] == $past(lookEntry[55:48]))
        else $error("IPv6 byte pair not swapped");
    a_bank_single: assert property ( // RULE_08
        cfgValid && cfgReq.addr < 17'h4
        |-> bank == cfg_map_pkg::BANK_REGS && !commitB && !commitC)
        else $error("register address reached a table bank");
    a_partial_hold: assert property ( // RULE_10
        cfgValid && cfgReq.write && bank == cfg_map_pkg::BANK_TAB_C && wrdC < 3'h5
        |-> !commitC)
        else $error("wide entry committed before its last word");

endmodule // cfg_address_map

// [tb/cfg_host_model.sv]
`timescale 1ns/10ps

module cfg_host_model (
    input  wire logic                 sys_clk,
    output logic                      cfgValid,
    output cfg_map_pkg::cfgReq_t      cfgReq,
    input  wire logic                 cfgAck,
    input  wire cfg_map_pkg::cfgRsp_t cfgRsp
);
    logic                 ackSeen;
    cfg_map_pkg::cfgRsp_t rspSeen;

    initial begin
        cfgValid = 1'b0;
        cfgReq = '0;
    end

    // one word per call; callers finish a wide entry before opening another
    task automatic access(input logic wr, input logic [16:0] addr, input logic [31:0] wdata);
        @(negedge sys_clk);
        cfgValid = 1'b1;
        cfgReq = '{write: wr, addr: addr, wdata: wdata};
        @(negedge sys_clk);
        ackSeen = cfgAck;
        rspSeen = cfgRsp;
        cfgValid = 1'b0;
        // idle bus shows the bitwise inverse of the last request
        cfgReq = ~cfgReq;
    endtask
endmodule // cfg_host_model

// [tb/tb.sv]
`timescale 1ns/10ps
`include "cfg_map_defs.svh"

module tb;
    logic                         sys_clk = 1'b0;
    logic                         rstn = 1'b0;
    logic                         cfgValid;
    cfg_map_pkg::cfgReq_t         cfgReq;
    logic                         cfgAck;
    cfg_map_pkg::cfgRsp_t         cfgRsp;
    logic [`REGS_WORDS-1:0][31:0] regsOut;
    logic                         lookupValid = 1'b0;
    logic [2:0]                   lookupIdx = 3'h0;
    logic                         fieldValid;
    cfg_map_pkg::netFields_t      fieldOut;
    logic [191:0]                 ent = '0;
    int                           errCount = 0;
    int                           nChecks = 0;
    int                           cycles = 0;

    always #4 sys_clk = ~sys_clk;

    cfg_address_map u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .cfgValid(cfgValid), .cfgReq(cfgReq),
        .cfgAck(cfgAck), .cfgRsp(cfgRsp), .regsOut(regsOut), .lookupValid(lookupValid),
        .lookupIdx(lookupIdx), .fieldValid(fieldValid), .fieldOut(fieldOut)
    );

    cfg_host_model u_host (
        .sys_clk(sys_clk), .cfgValid(cfgValid), .cfgReq(cfgReq),
        .cfgAck(cfgAck), .cfgRsp(cfgRsp)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [16:0] addr, input logic [31:0] exp);
        u_host.access(1'b0, addr, 32'h00000000);
        chk("cfgAck", 32'h00000001, u_host.ackSeen);
        chk("rdata", exp, u_host.rspSeen.rdata);
        chk("err", 32'h00000000, u_host.rspSeen.err);
    endtask

    task automatic t_regs();
        chk("regsOut", 32'h00000000, regsOut[0]);
        // write then read each word, so the read-back assertion sees the pair
        for (int i = 0; i < `REGS_WORDS; i++) begin
            u_host.access(1'b1, 17'(i), 32'hA1B2C3D4 + 32'(i));
            rd(17'(i), 32'hA1B2C3D4 + 32'(i));
            chk("regsOut", 32'hA1B2C3D4 + 32'(i), regsOut[i]);
        end
    endtask

    task automatic t_tab_b();
        u_host.access(1'b1, 17'h0002E, 32'hCAFE0001);
        u_host.access(1'b1, 17'h0002F, 32'hFFFFFFFF);
        rd(17'h0002E, 32'hCAFE0001);
        rd(17'h0002F, 32'h00000001);
        // first word alone must stay in the holding register
        u_host.access(1'b1, 17'h0002E, 32'h12345678);
        rd(17'h0002E, 32'hCAFE0001);
        u_host.access(1'b1, 17'h0002F, 32'h00000000);
        rd(17'h0002E, 32'h12345678);
        u_host.access(1'b1, 17'h00010, 32'h0000BEEF);
        u_host.access(1'b1, 17'h00011, 32'h00000001);
        rd(17'h00010, 32'h0000BEEF);
        rd(17'h0002E, 32'h12345678);
    endtask

    task automatic t_tab_c();
        for (int k = 0; k < 6; k++) begin
            ent[32*k +: 32] = 32'h03020100 + 32'h04040404 * 32'(k);
            u_host.access(1'b1, 17'h00078 + 17'(k), ent[32*k +: 32]);
        end
        rd(17'h00078, ent[31:0]);
        rd(17'h0007E, 32'h00000000);
        @(negedge sys_clk);
        lookupValid = 1'b1;
        lookupIdx = 3'h7;
        @(negedge sys_clk);
        lookupValid = 1'b0;
        lookupIdx = 3'h2;
        chk("fieldValid", 32'h00000001, fieldValid);
        for (int n = 0; n < 6; n++) begin
            chk("mac", ent[47-8*n -: 8], fieldOut.mac[n]);
        end
        for (int n = 0; n < 16; n++) begin
            chk("ipv6", ent[48+8*(n^1) +: 8], fieldOut.ipv6[n]);
        end
        @(negedge sys_clk);
        chk("fieldValid", 32'h00000000, fieldValid);
    endtask

    task automatic t_range();
        rd(17'h1097A, 32'h00000000);
        u_host.access(1'b1, 17'h1097B, 32'h5A5A5A5A);
        chk("err", 32'h00000001, u_host.rspSeen.err);
        u_host.access(1'b0, 17'h1097B, 32'h00000000);
        chk("err", 32'h00000001, u_host.rspSeen.err);
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errCount++;
            endOfTest();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_regs();
        t_tab_b();
        t_tab_c();
        t_range();
        endOfTest();
    end
endmodule // tb
